// File: logic/nvm_guard.sv
// Memory guard: bus start/stop watch, abort on reset, write cycle timer.
// Assumes filtered bus lines and a 1 us tick from the sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "sup_cfg.svh"

module nvm_guard #(
  parameter int PROG_TICKS = `NVM_PROGRAM_TIME_MS * `TICKS_PER_MS
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  guard_if.guard    gd
);

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  logic        scl_prev;
  logic        sda_prev;
  logic [12:0] prog_cnt;
  logic        next_txn_active;
  logic        next_txn_abort;
  logic        next_prog_start;
  logic        next_prog_busy;
  logic [12:0] next_prog_cnt;
  logic        bus_start;
  logic        bus_stop;
  logic        prog_done;

  assign bus_start = gd.scl_f && scl_prev && sda_prev && !gd.sda_f;
  assign bus_stop  = gd.scl_f && scl_prev && !sda_prev && gd.sda_f;
  assign prog_done = gd.tick && (prog_cnt == 13'(PROG_TICKS - 1));

  always_comb begin
    next_txn_active = gd.txn_active;
    next_txn_abort  = 1'h0;
    next_prog_start = 1'h0;
    next_prog_busy  = gd.prog_busy;
    next_prog_cnt   = prog_cnt;
    if (gd.prog_busy) begin
      // Runs to the end even under reset
      if (prog_done) begin
        next_prog_busy = 1'h0;
        next_prog_cnt  = 13'h0000;
      end else if (gd.tick) begin
        next_prog_cnt = prog_cnt + 13'h0001;
      end
    end
    if (gd.reset_active) begin
      next_txn_active = 1'h0;
      next_txn_abort  = gd.txn_active;
    end else if (bus_stop) begin
      next_txn_active = 1'h0;
      if (gd.txn_active && gd.write_data_seen && !gd.write_protect &&
          !gd.prog_busy) begin
        next_prog_start = 1'h1;
        next_prog_busy  = 1'h1;
        next_prog_cnt   = 13'h0000;
      end
    end else if (bus_start && !gd.prog_busy) begin
      next_txn_active = 1'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      scl_prev       <= 1'h1;
      sda_prev       <= 1'h1;
      gd.txn_active  <= 1'h0;
      gd.txn_abort   <= 1'h0;
      gd.prog_start  <= 1'h0;
      gd.prog_busy   <= 1'h0;
      gd.mem_enable  <= 1'h0;
      gd.write_allow <= 1'h0;
      prog_cnt       <= 13'h0000;
    end else begin
      scl_prev       <= gd.scl_f;
      sda_prev       <= gd.sda_f;
      gd.txn_active  <= next_txn_active;
      gd.txn_abort   <= next_txn_abort;
      gd.prog_start  <= next_prog_start;
      gd.prog_busy   <= next_prog_busy;
      gd.mem_enable  <= !gd.reset_active && !next_prog_busy;
      gd.write_allow <= !gd.reset_active && !next_prog_busy &&
                        !gd.write_protect;
      prog_cnt       <= next_prog_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  abort_on_reset_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    gd.reset_active && gd.txn_active |=> gd.txn_abort && !gd.txn_active)
    else $error("transaction not aborted by reset");

  no_prog_reset_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    gd.prog_start |-> !$past(gd.reset_active) && !$past(gd.write_protect))
    else $error("write cycle started under reset or protect");

  prog_survives_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    gd.prog_busy && !prog_done |=> gd.prog_busy)
    else $error("write cycle cut short");

  mem_off_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    gd.reset_active |=> !gd.mem_enable && !gd.write_allow)
    else $error("memory enabled under reset");

  bus_quiet_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    gd.prog_busy |-> !gd.mem_enable)
    else $error("bus served during write cycle");

endmodule

`default_nettype wire

// File: logic/spike_filter.sv
// Per-bit glitch filter: a level must hold STABLE cycles to pass.
// Assumes inputs synchronous to the core clock.
`timescale 1ns/100ps
`default_nettype none

module spike_filter #(
  parameter int               WIDTH     = 3,
  parameter int               STABLE    = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] raw_i,
  output var  logic [WIDTH-1:0] filt_o
);

  // ----------------------------------------------------------------
  // One counter per bit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_filt;

    always_comb begin
      next_cnt  = 8'h00;
      next_filt = filt_o[i];
      if (raw_i[i] != filt_o[i]) begin
        if (cnt == 8'(STABLE - 1)) begin
          next_filt = raw_i[i];
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        cnt       <= 8'h00;
        filt_o[i] <= RESET_VAL[i];
      end else begin
        cnt       <= next_cnt;
        filt_o[i] <= next_filt;
      end
    end

    // Written for the default of four cycles
    filt_hold_a: assert property (
      @(posedge core_clk_i) disable iff (srst_i)
      $changed(filt_o[i]) |->
        ($past(raw_i[i]) == filt_o[i]) && ($past(raw_i[i], 4) == filt_o[i]))
      else $error("filter passed a short pulse");
  end

endmodule

`default_nettype wire

// File: logic/supervisor_reset_and_memory_guard.sv
// Supervisory reset sequencer with watchdog and embedded memory guard.
// Assumes all inputs synchronous to core_clk_i; supply_ok_i is the
// abstract supply-above-threshold indication; the pin is open drain.
//
// Operation
// - after supply rises, reset holds one full 200 ms timeout.
// - once the timeout ends the reset pin is no longer driven.
// - supply falling below threshold asserts reset within 5 us.
// - an external edge to active level on the pin starts a timeout.
// - a short external reset still yields at least 200 ms of reset.
// - manual request low holds reset, then one full timeout follows.
// - manual request pulses under 100 ns are ignored.
// - a valid manual request asserts reset within 1 us.
// - clock and data spikes under 100 ns never count as bus edges.
// - the memory is disabled for every operation during reset.
// - reset aborts a running transaction and refuses new ones.
// - no write cycle starts under reset; a running one completes.
// - a write cycle starts at a write stop and lasts at most 5 ms.
// - during a write cycle the bus is idle and data released.
// - write protect high blocks every memory array write.
// - no watchdog transition for 1.6 s asserts reset.
// - the watchdog count is held clear while reset is asserted.
`timescale 1ns/100ps
`default_nettype none
`include "sup_cfg.svh"

module supervisor_reset_and_memory_guard
  import sup_pkg::*;
#(
  parameter int   RESET_TICKS  = `RESET_TIMEOUT_MS * `TICKS_PER_MS,
  parameter int   WD_TICKS     = `WATCHDOG_TIMEOUT_MS * `TICKS_PER_MS,
  parameter int   PROG_TICKS   = `NVM_PROGRAM_TIME_MS * `TICKS_PER_MS,
  parameter int   CNT_W        = 21,
  parameter logic ACTIVE_LEVEL = `RESET_ACTIVE_DEFAULT
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic supply_ok_i,
  input  wire logic manual_reset_request_n_i,
  input  wire logic reset_pin_i,
  output var  logic reset_pin_o,
  output var  logic reset_pin_oe_o,
  output var  logic reset_active_o,
  input  wire logic watchdog_kick_input_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic write_data_seen_i,
  input  wire logic write_protect_i,
  output var  logic scl_filt_o,
  output var  logic sda_filt_o,
  output var  logic mem_enable_o,
  output var  logic mem_write_allow_o,
  output var  logic mem_txn_active_o,
  output var  logic mem_abort_o,
  output var  logic nvm_prog_start_o,
  output var  logic nvm_prog_busy_o
);

  localparam int TICK_CYCLES = `TICK_CYCLES;

  // ----------------------------------------------------------------
  // Input filtering
  // ----------------------------------------------------------------
  logic [2:0] filt;
  logic       manual_reset_request_n_f;

  spike_filter #(
    .WIDTH     (3),
    .STABLE    (`SPIKE_CYCLES),
    .RESET_VAL (`FILTER_IDLE)
  ) u_filter (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .raw_i      ({manual_reset_request_n_i, sda_i, scl_i}),
    .filt_o     (filt)
  );

  assign manual_reset_request_n_f = filt[2];
  assign scl_filt_o               = filt[0];
  assign sda_filt_o               = filt[1];

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // One shared 1 us tick keeps every long count narrow
  logic [7:0] tick_div;
  logic [7:0] next_tick_div;
  logic       tick;
  logic       next_tick;

  always_comb begin
    next_tick     = 1'h0;
    next_tick_div = tick_div + 8'h01;
    if (tick_div == 8'(TICK_CYCLES - 1)) begin
      next_tick_div = 8'h00;
      next_tick     = 1'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tick_div <= 8'h00;
      tick     <= 1'h0;
    end else begin
      tick_div <= next_tick_div;
      tick     <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  sup_state_t       state;
  sup_state_t       next_state;
  logic [CNT_W-1:0] tmo_cnt;
  logic [CNT_W-1:0] next_tmo_cnt;
  logic             pin_prev;
  logic             ext_edge;
  logic             wd_expire;
  logic             next_drive;

  // Pin is only readable while released, so edges are seen in run
  assign ext_edge = (state == ST_RUN) && (pin_prev != ACTIVE_LEVEL) &&
                    (reset_pin_i == ACTIVE_LEVEL);

  always_comb begin
    next_state   = state;
    next_tmo_cnt = tmo_cnt;
    if (!supply_ok_i) begin
      next_state   = ST_HOLD_SUPPLY;
      next_tmo_cnt = '0;
    end else if (!manual_reset_request_n_f) begin
      next_state   = ST_HOLD_MANUAL;
      next_tmo_cnt = '0;
    end else begin
      case (state)
        ST_HOLD_SUPPLY, ST_HOLD_MANUAL: begin
          next_state   = ST_TIMEOUT;
          next_tmo_cnt = '0;
        end
        ST_TIMEOUT: begin
          // One extra tick covers the unknown phase of the time base
          if (tick && tmo_cnt == CNT_W'(RESET_TICKS)) begin
            next_state = ST_RUN;
          end else if (tick) begin
            next_tmo_cnt = tmo_cnt + 1'b1;
          end
        end
        ST_RUN: begin
          if (ext_edge || wd_expire) begin
            next_state   = ST_TIMEOUT;
            next_tmo_cnt = '0;
          end
        end
        default: begin
          next_state   = ST_HOLD_SUPPLY;
          next_tmo_cnt = '0;
        end
      endcase
    end
    next_drive = (next_state != ST_RUN);
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state          <= ST_HOLD_SUPPLY;
      tmo_cnt        <= '0;
      pin_prev       <= ~ACTIVE_LEVEL;
      reset_pin_oe_o <= 1'h1;
      reset_pin_o    <= ACTIVE_LEVEL;
      reset_active_o <= 1'h1;
    end else begin
      state          <= next_state;
      tmo_cnt        <= next_tmo_cnt;
      pin_prev       <= reset_pin_i;
      reset_pin_oe_o <= next_drive;
      reset_pin_o    <= next_drive ? ACTIVE_LEVEL : ~ACTIVE_LEVEL;
      reset_active_o <= next_drive;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] wd_cnt;
  logic [CNT_W-1:0] next_wd_cnt;
  logic             kick_prev;

  assign wd_expire = tick && (wd_cnt == CNT_W'(WD_TICKS - 1));

  always_comb begin
    next_wd_cnt = wd_cnt;
    if (reset_active_o) begin
      next_wd_cnt = '0;
    end else if (watchdog_kick_input_i != kick_prev || wd_expire) begin
      next_wd_cnt = '0;
    end else if (tick) begin
      next_wd_cnt = wd_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wd_cnt    <= '0;
      kick_prev <= 1'h0;
    end else begin
      wd_cnt    <= next_wd_cnt;
      kick_prev <= watchdog_kick_input_i;
    end
  end

  // ----------------------------------------------------------------
  // Memory guard
  // ----------------------------------------------------------------
  // Host must still honour its own power-up wait before access
  guard_if gd ();

  // Next value, so the memory stops in the first cycle of reset
  assign gd.reset_active    = next_drive;
  assign gd.tick            = tick;
  assign gd.scl_f           = filt[0];
  assign gd.sda_f           = filt[1];
  assign gd.write_data_seen = write_data_seen_i;
  assign gd.write_protect   = write_protect_i;

  nvm_guard #(
    .PROG_TICKS (PROG_TICKS)
  ) u_guard (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .gd         (gd.guard)
  );

  assign mem_enable_o      = gd.mem_enable;
  assign mem_write_allow_o = gd.write_allow;
  assign mem_txn_active_o  = gd.txn_active;
  assign mem_abort_o       = gd.txn_abort;
  assign nvm_prog_start_o  = gd.prog_start;
  assign nvm_prog_busy_o   = gd.prog_busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int unsigned hold_cycles;

  always_ff @(posedge core_clk_i) begin
    if (srst_i || state != ST_TIMEOUT) begin
      hold_cycles <= 0;
    end else begin
      hold_cycles <= hold_cycles + 1;
    end
  end

  supply_drop_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    !supply_ok_i |=> reset_pin_oe_o && reset_pin_o == ACTIVE_LEVEL)
    else $error("reset late after supply drop");

  manual_hold_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    $fell(manual_reset_request_n_i) ##4 !manual_reset_request_n_f
      |=> reset_pin_oe_o)
    else $error("manual request not answered");

  release_float_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    !reset_pin_oe_o && supply_ok_i && manual_reset_request_n_f &&
      !ext_edge && !wd_expire |=> !reset_pin_oe_o)
    else $error("pin driven with no reset source");

  timeout_len_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    $fell(reset_pin_oe_o) |->
      $past(hold_cycles) >= RESET_TICKS * TICK_CYCLES &&
      $past(hold_cycles) <= (RESET_TICKS + 2) * TICK_CYCLES)
    else $error("reset timeout length wrong");

  ext_edge_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    ext_edge && supply_ok_i |=> state == ST_TIMEOUT || state == ST_HOLD_MANUAL)
    else $error("external edge missed");

  wd_held_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    reset_active_o |=> wd_cnt == '0)
    else $error("watchdog counted during reset");

  wd_expire_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    wd_expire && state == ST_RUN && supply_ok_i |=> reset_pin_oe_o)
    else $error("watchdog expiry ignored");

  level_a: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    reset_active_o |-> reset_pin_o == ACTIVE_LEVEL && reset_pin_oe_o)
    else $error("reset level wrong");

endmodule

`default_nettype wire

// File: shared/guard_if.sv
// Signals between the reset sequencer and the memory guard.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
`default_nettype none

interface guard_if;
  logic reset_active;
  logic tick;
  logic scl_f;
  logic sda_f;
  logic write_data_seen;
  logic write_protect;
  logic mem_enable;
  logic write_allow;
  logic txn_abort;
  logic txn_active;
  logic prog_start;
  logic prog_busy;

  modport ctl (
    output reset_active, tick, scl_f, sda_f, write_data_seen,
           write_protect,
    input  mem_enable, write_allow, txn_abort, txn_active, prog_start,
           prog_busy
  );

  modport guard (
    input  reset_active, tick, scl_f, sda_f, write_data_seen,
           write_protect,
    output mem_enable, write_allow, txn_abort, txn_active, prog_start,
           prog_busy
  );
endinterface

`default_nettype wire

// File: shared/sup_cfg.svh
// Timing and reset constants for the supervisor and memory guard.
// Assumes a 40 MHz core clock and a 1 us internal time base.
`ifndef SUP_CFG_SVH
`define SUP_CFG_SVH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        25
`define TICK_PERIOD_NS       1000
`define TICK_CYCLES          (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICKS_PER_MS         1000

// ----------------------------------------------------------------
// Timeouts
// ----------------------------------------------------------------
`define RESET_TIMEOUT_MS     200
`define WATCHDOG_TIMEOUT_MS  1600
`define NVM_PROGRAM_TIME_MS  5
`define SPIKE_FILTER_NS      100
`define SPIKE_CYCLES         (`SPIKE_FILTER_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FILTER_IDLE          3'h7
`define RESET_ACTIVE_DEFAULT 1'h0

`endif

// File: shared/sup_pkg.sv
// Types used by the supervisor only; its filter and memory guard import none.
// Assumes nothing of its surroundings.
package sup_pkg;

  // ----------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD_SUPPLY,
    ST_HOLD_MANUAL,
    ST_TIMEOUT,
    ST_RUN
  } sup_state_t;

endpackage

// File: tb/host_side.sv
// Far-side model: pulled-up reset line and two-wire bus master.
// Assumes an active-low reset pin and drive just after clk_i edges.
`timescale 1ns/100ps
`default_nettype none

module host_side (
  input  wire logic clk_i,
  input  wire logic pin_drv_i,
  input  wire logic pin_oe_i,
  output var  logic pin_o,
  output var  logic scl_o,
  output var  logic sda_o
);
  logic pull_low;

  // ----------------------------------------------------------------
  // Reset line
  // ----------------------------------------------------------------
  // Released line floats to the pull-up, never to a stale value
  always_comb pin_o = pin_oe_i ? pin_drv_i : !pull_low;

  initial begin
    pull_low = 1'b0;
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold_low(input int n);
    @(posedge clk_i) pull_low <= 1'b1;
    repeat (n) @(posedge clk_i);
    pull_low <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  // Also called while the supervisor holds reset, in the abort test
  task automatic bus_edge(input logic sda_v, input int n);
    @(posedge clk_i) scl_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    sda_o <= sda_v;
    repeat (n) @(posedge clk_i);
  endtask

  // Two-cycle dip, shorter than the filter window
  task automatic bus_glitch;
    bus_edge(1'b0, 2);
    sda_o <= 1'b1;
  endtask
endmodule

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the supervisor and memory guard.
// Assumes shortened counts: 20/50/10 ticks of 40 cycles.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam int TK = 40;
  localparam int RLO = 20 * TK - 5;
  localparam int RHI = 22 * TK + 5;
  logic       clk, srst, supply_ok, pb_n, pin, pin_drv, pin_oe, rst_act;
  logic       scl, sda, wds, wp, scl_f, sda_f, men, mwa, mta, mab;
  logic       pst, pbz, kick_en;
  logic       wdk = 1'b0;
  logic [7:0] kcnt = 8'h00;
  int         err_total, n_compared;

  supervisor_reset_and_memory_guard #(
    .RESET_TICKS(20), .WD_TICKS(50), .PROG_TICKS(10)
  ) dut (
    .core_clk_i(clk), .srst_i(srst), .supply_ok_i(supply_ok),
    .manual_reset_request_n_i(pb_n), .reset_pin_i(pin),
    .reset_pin_o(pin_drv), .reset_pin_oe_o(pin_oe),
    .reset_active_o(rst_act), .watchdog_kick_input_i(wdk),
    .scl_i(scl), .sda_i(sda), .write_data_seen_i(wds),
    .write_protect_i(wp), .scl_filt_o(scl_f), .sda_filt_o(sda_f),
    .mem_enable_o(men), .mem_write_allow_o(mwa), .mem_txn_active_o(mta),
    .mem_abort_o(mab), .nvm_prog_start_o(pst), .nvm_prog_busy_o(pbz)
  );

  host_side host (
    .clk_i(clk), .pin_drv_i(pin_drv), .pin_oe_i(pin_oe),
    .pin_o(pin), .scl_o(scl), .sda_o(sda)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Background kicks keep the watchdog quiet outside its own test
  always @(posedge clk) begin
    kcnt <= kcnt + 8'h01;
    if (kick_en && kcnt == 8'hFF) wdk <= ~wdk;
  end

  task automatic chk(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, hi, g);
    n_compared++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("ERROR %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask

  task automatic wait_rst(input logic lvl, output int n);
    n = 0;
    while (rst_act !== lvl && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  task automatic watch(input int n, output logic ab, ps);
    ab = 1'b0;
    ps = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 ab |= (mab === 1'b1);
      ps |= (pst === 1'b1);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power;
    int n;
    repeat (50) @(posedge clk);
    #1 chk("pin_oe", 1'b1, pin_oe);
    chk("pin_level", 1'b0, pin);
    @(posedge clk) supply_ok <= 1'b1;
    wait_rst(1'b0, n);
    chk_rng("powerup_len", RLO, RHI, n);
    chk("pin_oe", 1'b0, pin_oe);
    chk("pin_level", 1'b1, pin);
    $display("test power-up done");
  endtask

  task automatic t_brown;
    int n;
    @(posedge clk) supply_ok <= 1'b0;
    #1 wait_rst(1'b1, n);
    chk_rng("brownout_delay", 0, 200, n);
    chk("mem_enable", 1'b0, men);
    @(posedge clk) supply_ok <= 1'b1;
    wait_rst(1'b0, n);
    chk_rng("brownout_len", RLO, RHI, n);
    $display("test brownout done");
  endtask

  task automatic t_manual;
    int n;
    @(posedge clk) pb_n <= 1'b0;
    repeat (2) @(posedge clk);
    pb_n <= 1'b1;
    repeat (30) @(posedge clk);
    #1 chk("short_pulse", 1'b0, rst_act);
    @(posedge clk) pb_n <= 1'b0;
    #1 wait_rst(1'b1, n);
    chk_rng("manual_delay", 0, 40, n);
    repeat (1200) @(posedge clk);
    #1 chk("manual_hold", 1'b1, rst_act);
    @(posedge clk) pb_n <= 1'b1;
    wait_rst(1'b0, n);
    chk_rng("manual_len", RLO, RHI, n);
    $display("test manual done");
  endtask

  task automatic t_ext;
    int n;
    host.hold_low(10);
    #1 chk("ext_reset", 1'b1, rst_act);
    wait_rst(1'b0, n);
    chk_rng("ext_len", RLO - 20, RHI, n + 11);
    $display("test external pin done");
  endtask

  task automatic t_write;
    int n;
    logic ab, ps;
    host.bus_edge(1'b0, 20);
    @(posedge clk) wds <= 1'b1;
    host.bus_edge(1'b1, 0);
    n = 0;
    while (pst !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk("prog_start", 1'b1, pst);
    @(posedge clk) wds <= 1'b0;
    pb_n <= 1'b0;
    #1 chk("prog_busy", 1'b1, pbz);
    chk("mem_enable", 1'b0, men);
    n = 1;
    while (pbz === 1'b1 && n < 1000) begin
      @(posedge clk);
      #1 n++;
    end
    chk_rng("prog_len", 9 * TK, 11 * TK, n);
    @(posedge clk) pb_n <= 1'b1;
    wait_rst(1'b0, n);
    watch(2, ab, ps);
    chk("write_allow", 1'b1, mwa);
    $display("test write cycle done");
  endtask

  task automatic t_wp;
    logic ab, ps;
    @(posedge clk) wp <= 1'b1;
    host.bus_edge(1'b0, 20);
    @(posedge clk) wds <= 1'b1;
    host.bus_edge(1'b1, 0);
    watch(20, ab, ps);
    chk("wp_prog", 1'b0, ps);
    chk("write_allow", 1'b0, mwa);
    @(posedge clk) wp <= 1'b0;
    wds <= 1'b0;
    $display("test write protect done");
  endtask

  task automatic t_abort;
    int n;
    logic ab, ps;
    host.bus_edge(1'b0, 20);
    #1 chk("txn_active", 1'b1, mta);
    @(posedge clk) pb_n <= 1'b0;
    wds <= 1'b1;
    watch(20, ab, ps);
    chk("abort", 1'b1, ab);
    chk("txn_active", 1'b0, mta);
    chk("mem_enable", 1'b0, men);
    host.bus_edge(1'b1, 0);
    watch(20, ab, ps);
    chk("prog_in_reset", 1'b0, ps);
    host.bus_edge(1'b0, 20);
    #1 chk("start_in_reset", 1'b0, mta);
    host.bus_edge(1'b1, 10);
    pb_n <= 1'b1;
    wds <= 1'b0;
    wait_rst(1'b0, n);
    $display("test abort done");
  endtask

  task automatic t_spike;
    logic dip, txn;
    dip = 1'b0;
    txn = 1'b0;
    fork
      host.bus_glitch;
      repeat (14) begin
        @(posedge clk);
        #1 dip |= (sda_f !== 1'b1) || (scl_f !== 1'b1);
        txn |= (mta === 1'b1);
      end
    join
    chk("spike_txn", 1'b0, txn);
    chk("sda_filt", 1'b0, dip);
    $display("test spike done");
  endtask

  task automatic t_wdog;
    int n;
    @(posedge clk) kick_en <= 1'b0;
    pb_n <= 1'b0;
    repeat (100) @(posedge clk);
    pb_n <= 1'b1;
    wait_rst(1'b0, n);
    wait_rst(1'b1, n);
    chk_rng("wdog_len", 49 * TK, 52 * TK, n);
    @(posedge clk) kick_en <= 1'b1;
    wait_rst(1'b0, n);
    repeat (2100) @(posedge clk);
    #1 chk("wdog_kicked", 1'b0, rst_act);
    $display("test watchdog done");
  endtask

  initial begin
    srst = 1'b1;
    supply_ok = 1'b0;
    pb_n = 1'b1;
    wds = 1'b0;
    wp = 1'b0;
    kick_en = 1'b1;
    err_total = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_power;
    t_brown;
    t_manual;
    t_ext;
    t_write;
    t_wp;
    t_abort;
    t_spike;
    t_wdog;
    give_verdict;
  end

  initial begin
    #(40000 * 25);
    err_total++;
    give_verdict;
  end
endmodule

`default_nettype wire
